// ---- hw/fieldbus_enable_defines.svh ----
/*
  Constants of the fieldbus enable register bank: register indices, byte address scale,
  field positions, reset values and timing figures.
  Assumes it is included by bare name from the files that need it.
*/
`ifndef FIELDBUS_ENABLE_DEFINES_SVH
`define FIELDBUS_ENABLE_DEFINES_SVH

// register indices; byte address is index times four
`define IDX_PULSE_MODE 16'h205b
`define IDX_READY_DELAY 16'h2084
`define IDX_FB_AVAIL 16'h2101
`define IDX_FB_CONTROL 16'h2102
`define IDX_FB_SWITCHABLE 16'h2180
`define IDX_FB_ACTIVE 16'h2181
`define ADDR_SHIFT 2

// reset values
`define RST_PULSE_MODE 32'h0000_0000
`define RST_READY_DELAY 32'h0000_0000
`define RST_FB_AVAIL 32'h0019_0021
`define RST_FB_CONTROL 32'h0019_0021
`define RST_FB_SWITCHABLE 32'h0000_0000

// fieldbus bit positions: interfaces low half, protocols high half
`define BIT_USB 0
`define BIT_DIFF_SERIAL 1
`define BIT_SINGLE_ENDED_SERIAL 2
`define BIT_CAN 3
`define BIT_ETHERNET_IFACE 4
`define BIT_IND_ETH_SLAVE 5
`define BIT_SPI 6
`define BIT_MODBUS_RTU 16
`define BIT_MODBUS_TCP 17
`define BIT_IND_ETH_APP_PROTOCOL 18
`define IFACE_LSB 0
`define IFACE_MSB 15
`define PROTO_LSB 16
`define PROTO_MSB 31

// pulse-input mode selector values
`define PULSE_SEL_CLOCK_DIR 32'h0000_0000
`define PULSE_SEL_ROTATION 32'h0000_0001

// timing: one millisecond at the 100 MHz clock
`define CLK_PERIOD_PS 10000
`define MS_IN_PS 1000000000
`define CYCLES_PER_MS (`MS_IN_PS / `CLK_PERIOD_PS)

`endif

// ---- hw/fieldbus_enable_pkg.sv ----
/*
  Types shared by the fieldbus enable register bank.
  Assumes the defines header carries all numeric constants.
*/
package fieldbus_enable_pkg;
  // decoded pulse-input mode
  typedef enum logic {
    PULSE_CLOCK_DIR,
    PULSE_ROTATION
  } pulse_mode_e;

  // readiness sequencer states
  typedef enum logic [1:0] {
    RDY_START,
    RDY_WAIT,
    RDY_DONE
  } ready_state_e;

  typedef logic [31:0] word_t;
endpackage : fieldbus_enable_pkg

// ---- hw/masked_word_reg.sv ----
/*
  A 32-bit software register with byte enables and a per-bit write permission mask.
  Assumes write strobe and data come from logic on the same clock.
*/
`timescale 1ns/1ps
module masked_word_reg #(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] wmask_i,
  output logic [31:0] q_o
);
  import fieldbus_enable_pkg::*;

  word_t lane_w; // bits selected by byte enables
  word_t allow_w; // bits both selected and permitted

  // expand byte enables to bit lanes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_w[i*8 +: 8] = {8{sel_i[i]}};
    end
    allow_w = lane_w & wmask_i;
  end

  // bits outside the permission mask keep their value whatever is written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= RESET_VALUE;
    end else if (we_i) begin
      q_o <= (q_o & ~allow_w) | (wdata_i & allow_w);
    end
  end
endmodule : masked_word_reg

// ---- hw/ready_delay_timer.sv ----
/*
  Readiness sequencer: after reset, holds not-ready for a programmable number of milliseconds.
  Assumes the delay value comes from a register on the same clock.
*/
`timescale 1ns/1ps
`include "fieldbus_enable_defines.svh"
module ready_delay_timer #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] delay_ms_i,
  output logic ready_o
);
  import fieldbus_enable_pkg::*;

  localparam int CW = $clog2(CYCLES_PER_MS + 1);

  generate
    if (CYCLES_PER_MS < 1) begin : g_bad
      $error("CYCLES_PER_MS must be at least 1");
    end
  endgenerate

  ready_state_e state_r;
  logic [CW-1:0] div_r; // cycle divider within one millisecond
  logic [31:0] ms_r; // milliseconds elapsed while waiting
  logic ms_tick_w; // one-cycle pulse per millisecond

  assign ms_tick_w = (div_r == CW'(CYCLES_PER_MS - 1));

  // millisecond divider runs only while waiting
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != RDY_WAIT || ms_tick_w) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + CW'(1);
    end
  end

  // elapsed time; saturates so a huge delay cannot wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_r <= 32'h0000_0000;
    end else if (ms_tick_w && ms_r != 32'hffff_ffff) begin
      ms_r <= ms_r + 32'h0000_0001;
    end
  end

  // once ready, stays ready until the next reset; a later delay write has no effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RDY_START;
    end else begin
      unique case (state_r)
        RDY_START: state_r <= RDY_WAIT;
        RDY_WAIT: if (ms_r >= delay_ms_i) state_r <= RDY_DONE;
        RDY_DONE: state_r <= RDY_DONE;
      endcase
    end
  end

  // registered readiness output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= (state_r == RDY_DONE);
    end
  end
endmodule : ready_delay_timer

// ---- hw/fieldbus_enable_regs.sv ----
/*
  Fieldbus enable register bank: pulse-input mode selector, power-up readiness delay,
  fieldbus availability, fieldbus enable control, switchable mask and live activation status,
  reached over a classic Wishbone slave with 32-bit data.
  Assumes a single 100 MHz clock and a synchronous active-high reset; the bus master is on
  the same clock.
*/
// Notes on behaviour
// - stay not-ready for programmed milliseconds after reset
// - low half interfaces, high half protocols
// - interface bits zero to six, one each
// - protocol bits sixteen to eighteen
// - availability word read-only, fixed preset pattern
// - control word read/write, same bits, same preset
// - only switchable fieldbuses accept control writes
// - active fieldbuses shown in separate status word
// - mode selector 32-bit read/write, preset zero
// - zero clock-direction, one rotation mode
`timescale 1ns/1ps
`include "fieldbus_enable_defines.svh"
module fieldbus_enable_regs #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter logic [31:0] SWITCHABLE_MASK = `RST_FB_SWITCHABLE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // block outputs
  output fieldbus_enable_pkg::pulse_mode_e pulse_mode_o,
  output logic ready_o,
  output logic [31:0] fb_active_o
);
  import fieldbus_enable_pkg::*;

  generate
    if (CYCLES_PER_MS < 1) begin : g_bad_rate
      $error("CYCLES_PER_MS must be at least 1");
    end
  endgenerate

  localparam logic [15:0] ADDR_MODE = 16'(`IDX_PULSE_MODE << `ADDR_SHIFT);
  localparam logic [15:0] ADDR_DELAY = 16'(`IDX_READY_DELAY << `ADDR_SHIFT);
  localparam logic [15:0] ADDR_AVAIL = 16'(`IDX_FB_AVAIL << `ADDR_SHIFT);
  localparam logic [15:0] ADDR_CONTROL = 16'(`IDX_FB_CONTROL << `ADDR_SHIFT);
  localparam logic [15:0] ADDR_SWITCH = 16'(`IDX_FB_SWITCHABLE << `ADDR_SHIFT);
  localparam logic [15:0] ADDR_ACTIVE = 16'(`IDX_FB_ACTIVE << `ADDR_SHIFT);

  // fixed availability pattern; the product provides usb, industrial-ethernet slave,
  // modbus rtu and high-half bits 19 and 20; the application protocol bit 18 is clear
  localparam word_t AVAIL_WORD = `RST_FB_AVAIL;

  logic ack_r; // answer strobe, one cycle
  logic take_w; // request taken this edge
  logic wr_w; // write taken this edge
  word_t mode_q; // pulse-input mode selector
  word_t delay_q; // readiness delay in ms
  word_t control_q; // requested enables
  word_t active_r; // live activation status
  word_t rdata_nxt; // read mux
  logic hit_w; // address maps to a register

  // a request is taken once, on the edge before ack rises
  assign take_w = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_w = take_w && wb_we_i;

  // ack follows one cycle after the request and drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take_w;
    end
  end
  assign wb_ack_o = ack_r;

  // mode selector: any 32-bit value is stored and read back
  masked_word_reg #(
    .RESET_VALUE(`RST_PULSE_MODE)
  ) u_mode (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr_w && wb_adr_i == ADDR_MODE),
    .sel_i(wb_sel_i),
    .wdata_i(wb_dat_i),
    .wmask_i(32'hffff_ffff),
    .q_o(mode_q)
  );

  // readiness delay, milliseconds
  masked_word_reg #(
    .RESET_VALUE(`RST_READY_DELAY)
  ) u_delay (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr_w && wb_adr_i == ADDR_DELAY),
    .sel_i(wb_sel_i),
    .wdata_i(wb_dat_i),
    .wmask_i(32'hffff_ffff),
    .q_o(delay_q)
  );

  // control word: the switchable mask is the write permission, so bits of buses
  // that cannot be switched are never touched by software
  masked_word_reg #(
    .RESET_VALUE(`RST_FB_CONTROL)
  ) u_control (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr_w && wb_adr_i == ADDR_CONTROL),
    .sel_i(wb_sel_i),
    .wdata_i(wb_dat_i),
    .wmask_i(SWITCHABLE_MASK),
    .q_o(control_q)
  );

  // power-up readiness sequencer
  ready_delay_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_ready (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .delay_ms_i(delay_q),
    .ready_o(ready_o)
  );

  // decode the selector; values other than rotation fall back to clock-direction
  always_comb begin
    if (mode_q == `PULSE_SEL_ROTATION) begin
      pulse_mode_o = PULSE_ROTATION;
    end else begin
      pulse_mode_o = PULSE_CLOCK_DIR;
    end
  end

  // a bus is active only once the device is ready, it is requested and it exists;
  // interface bits in the low half, protocol bits in the high half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= 32'h0000_0000;
    end else if (ready_o) begin
      active_r[`IFACE_MSB:`IFACE_LSB] <= control_q[`IFACE_MSB:`IFACE_LSB] &
        AVAIL_WORD[`IFACE_MSB:`IFACE_LSB];
      active_r[`PROTO_MSB:`PROTO_LSB] <= control_q[`PROTO_MSB:`PROTO_LSB] &
        AVAIL_WORD[`PROTO_MSB:`PROTO_LSB];
    end else begin
      active_r <= 32'h0000_0000;
    end
  end
  assign fb_active_o = active_r;

  // read multiplexer; unmapped addresses answer zero
  always_comb begin
    hit_w = 1'b1;
    unique case (wb_adr_i)
      ADDR_MODE: rdata_nxt = mode_q;
      ADDR_DELAY: rdata_nxt = delay_q;
      ADDR_AVAIL: rdata_nxt = AVAIL_WORD;
      ADDR_CONTROL: rdata_nxt = control_q;
      ADDR_SWITCH: rdata_nxt = SWITCHABLE_MASK;
      ADDR_ACTIVE: rdata_nxt = active_r;
      default: begin
        rdata_nxt = 32'h0000_0000;
        hit_w = 1'b0;
      end
    endcase
  end

  // read data registered together with ack; zero on writes and unmapped reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (take_w && !wb_we_i && hit_w) begin
      wb_dat_o <= rdata_nxt;
    end else if (take_w) begin
      wb_dat_o <= 32'h0000_0000;
    end
  end
endmodule : fieldbus_enable_regs

// ---- tb/fieldbus_enable_regs_monitor.sv ----
/*
  checker for the fieldbus enable register bank: bus answer, readiness and status word.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module fieldbus_enable_regs_monitor #(
  parameter int CYCLES_PER_MS = 4,
  parameter logic [31:0] SWITCHABLE_MASK = 32'h0000_0000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire fieldbus_enable_pkg::pulse_mode_e pulse_mode_o,
  input wire logic ready_o,
  input wire logic [31:0] fb_active_o
);
  import fieldbus_enable_pkg::*;
  // request taken at this edge
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (req |=> wb_ack_o) else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  // preset delay is zero, so readiness follows release within a few edges
  AST_READY_BOOT: assert property ($fell(rst_i) |-> !ready_o ##1 !ready_o ##[1:3] ready_o)
    else $error("readiness timing wrong after reset");
  AST_READY_HOLD: assert property (ready_o |=> ready_o) else $error("readiness dropped");
  AST_ACTIVE_GATED: assert property (!ready_o |-> fb_active_o == 32'h0000_0000)
    else $error("active word nonzero before ready");
  AST_ACTIVE_SUBSET: assert property ((fb_active_o & ~32'h0019_0021) == 32'h0000_0000)
    else $error("active bit outside availability");
  AST_ACTIVE_FIXED: assert property (ready_o && $past(ready_o) |->
    ((fb_active_o ^ 32'h0019_0021) & ~SWITCHABLE_MASK) == 32'h0000_0000) else $error("fixed bus changed");
  AST_MODE_DECODE: assert property (req && wb_we_i && wb_adr_i == 16'h816c && wb_sel_i == 4'hf |=>
    pulse_mode_o == ($past(wb_dat_i) == 32'h0000_0001 ? PULSE_ROTATION : PULSE_CLOCK_DIR))
    else $error("mode decode wrong");
  AST_AVAIL_READ: assert property (req && !wb_we_i && wb_adr_i == 16'h8404 |=>
    wb_ack_o && wb_dat_o == 32'h0019_0021) else $error("availability read wrong");
endmodule : fieldbus_enable_regs_monitor

bind fieldbus_enable_regs fieldbus_enable_regs_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS),
  .SWITCHABLE_MASK(SWITCHABLE_MASK)) fieldbus_enable_regs_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pulse_mode_o(pulse_mode_o),
  .ready_o(ready_o), .fb_active_o(fb_active_o));

// ---- tb/fieldbus_enable_regs_tb_top.sv ----
/*
  testbench for the fieldbus enable register bank: register sequences over classic wishbone.
  assumes the design answers every request with a one-cycle ack.
*/
`timescale 1ns/1ps
module fieldbus_enable_regs_tb_top;
  import fieldbus_enable_pkg::*;
  localparam logic [31:0] SW_MASK = 32'h0001_0001; // usb and serial protocol may be switched
  localparam logic [31:0] AVAIL = 32'h0019_0021;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wb_ack_o, ready_o;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, wb_dat_o, fb_active_o, rd;
  pulse_mode_e pulse_mode_o;
  int n_fail = 0, num_checks = 0;
  always #5 clk_i = ~clk_i;
  // short millisecond keeps any delay countdown small
  fieldbus_enable_regs #(.CYCLES_PER_MS(4), .SWITCHABLE_MASK(SW_MASK)) fieldbus_enable_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pulse_mode_o(pulse_mode_o), .ready_o(ready_o), .fb_active_o(fb_active_o));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // one classic cycle; request held until ack is sampled, then one idle cycle
  task automatic xfer(input logic [15:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    @(posedge clk_i);
    // only the watchdog ends a wait for the answer
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task automatic wr_chk(input string what, input logic [15:0] a, input logic [3:0] s,
    input logic [31:0] d, input logic [31:0] exp);
    xfer(a, 1'b1, s, d);
    xfer(a, 1'b0, 4'hf, 32'h0000_0000);
    check(what, rd, exp);
  endtask : wr_chk
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset
  // presets of every word except the active status word, the unmapped place last
  task automatic check_presets;
    logic [15:0] a [6] = '{16'h816c, 16'h8210, 16'h8404, 16'h8408, 16'h8600, 16'h0000};
    logic [31:0] e [6] = '{32'h0000_0000, 32'h0000_0000, AVAIL, AVAIL, SW_MASK, 32'h0000_0000};
    for (int i = 0; i < 6; i++) begin
      xfer(a[i], 1'b0, 4'hf, 32'h0000_0000);
      check("preset", rd, e[i]);
    end
  endtask : check_presets
  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
  initial begin
    logic [31:0] mv [3] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0002};
    pulse_mode_e me [3] = '{PULSE_ROTATION, PULSE_CLOCK_DIR, PULSE_CLOCK_DIR};
    do_reset();
    check("ready", {31'h0, ready_o}, 32'h0000_0000);
    check_presets();
    check("ready", {31'h0, ready_o}, 32'h0000_0001);
    check("active", fb_active_o, AVAIL);
    xfer(16'h8604, 1'b0, 4'hf, 32'h0000_0000);
    check("active_reg", rd, AVAIL);
    wr_chk("avail", 16'h8404, 4'hf, 32'hffff_ffff, AVAIL);
    wr_chk("unmapped", 16'h0000, 4'hf, 32'hffff_ffff, 32'h0000_0000);
    wr_chk("delay", 16'h8210, 4'h2, 32'haabb_ccdd, 32'h0000_cc00);
    for (int i = 0; i < 3; i++) begin
      wr_chk("mode", 16'h816c, 4'hf, mv[i], mv[i]);
      check("decode", {31'h0, pulse_mode_o}, {31'h0, me[i]});
    end
    // clearing all: only usb and the serial protocol may drop
    wr_chk("control", 16'h8408, 4'hf, 32'h0000_0000, 32'h0018_0020);
    check("active", fb_active_o, 32'h0018_0020);
    wr_chk("control", 16'h8408, 4'hf, 32'hffff_ffff, AVAIL);
    wr_chk("control", 16'h8408, 4'h4, 32'h0000_0000, 32'h0018_0021);
    do_reset();
    check_presets();
    finish_test();
  end
endmodule : fieldbus_enable_regs_tb_top
